// ### design/bpcs_pkg.sv
/*
 * package for the base-r pcs signal-detect, loopback and test-pattern block:
 * register offsets, field positions, reset values, pattern modes and carrier structs.
 * assumes a 32-bit axi4-lite register bus and 66-bit pcs blocks (2-bit header, 64-bit data) on the line side.
 */
package bpcs_pkg;
    localparam logic [7:0] OFS_PCS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_SIGDET_CONFIG = 8'h04;
    localparam logic [7:0] OFS_TEST_SETUP = 8'h08;
    localparam logic [7:0] OFS_SEED_A_UPPER = 8'h0C;
    localparam logic [7:0] OFS_SEED_A_LOWER = 8'h10;
    localparam logic [7:0] OFS_SEED_B_UPPER = 8'h14;
    localparam logic [7:0] OFS_SEED_B_LOWER = 8'h18;
    localparam logic [7:0] OFS_TX_PAT_UPPER = 8'h1C;
    localparam logic [7:0] OFS_TX_PAT_LOWER = 8'h20;
    localparam logic [7:0] OFS_RX_PAT_UPPER = 8'h24;
    localparam logic [7:0] OFS_RX_PAT_LOWER = 8'h28;
    localparam logic [7:0] OFS_STATE_FLAGS = 8'h2C;
    localparam logic [7:0] OFS_ERR_COUNT = 8'h30;

    // pcs_control fields
    localparam int CTL_TX_TEST_BIT = 0;
    localparam int CTL_RX_TEST_BIT = 1;
    localparam int CTL_LOOPBACK_BIT = 2;
    localparam int CTL_SEED_B_BIT = 3;
    // sigdet_config fields
    localparam int SD_ENABLE_BIT = 0;
    localparam int SD_POLARITY_BIT = 1;
    localparam int SD_SOURCE_BIT = 2;
    // test_pattern_setup fields
    localparam int TST_TX_SEL_LSB = 0;
    localparam int TST_RX_SEL_LSB = 4;
    // pcs_state_flags fields
    localparam int STA_MATCH_BIT = 0;
    localparam int STA_SIGDET_BIT = 1;
    localparam int STA_RX_RUN_BIT = 2;

    localparam int SEED_UPPER_W = 26;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] SD_RESET = 32'h0000_0002;
    localparam logic [31:0] TST_RESET = 32'h0000_0000;
    localparam logic [31:0] SLV_OKAY_RD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [63:0] SQUARE_HI = 64'hFFFF_FFFF_0000_0000;

    typedef enum logic [1:0] {
        PAT_SQUARE,
        PAT_PSEUDO,
        PAT_PRBS31,
        PAT_USER
    } bpcs_pat_e;

    typedef struct packed {
        logic [1:0] hdr;
        logic [63:0] data;
    } bpcs_blk_s;
endpackage

// ### design/bpcs_top.sv
/*
 * base-r pcs side logic: signal detect qualification, tx-to-rx loopback, test
 * pattern generator and checker, and an axi4-lite register slave.
 * assumes one 250 mhz clock for bus and pcs, synchronous inputs, and that the
 * downstream receive consumer may stall through rx_out_ready.
 */
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module bpcs_top
    import bpcs_pkg::*;
#(
    parameter int ERR_W = 32,
    parameter int WINDOW_BLKS = 128
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire bpcs_blk_s tx_in,
    output bpcs_blk_s tx_out,
    input wire bpcs_blk_s rx_in,
    input wire logic serdes_sigdet,
    input wire logic gpio_sigdet,
    output bpcs_blk_s rx_out,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output logic rx_restart
);
    initial begin
        if (ERR_W < 1 || ERR_W > 32 || WINDOW_BLKS < 2 || WINDOW_BLKS > 256) begin
            $error("bpcs_top: unsupported parameter");
        end
    end

    logic [31:0] ctl_ff, sd_ff, tst_ff;
    logic [31:0] seed_a_hi_ff, seed_a_lo_ff, seed_b_hi_ff, seed_b_lo_ff;
    logic [31:0] txp_hi_ff, txp_lo_ff, rxp_hi_ff, rxp_lo_ff;
    logic [ERR_W-1:0] err_cnt_ff;
    logic match_ff;

    // axi write side
    logic aw_held_ff, w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic wr_go;
    logic err_clr;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    function automatic logic addr_known(input logic [7:0] a);
        if (a[1:0] != 2'b00) begin
            return 1'b0;
        end else if (a > OFS_ERR_COUNT) begin
            return 1'b0;
        end else begin
            return 1'b1;
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (wr_go) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (addr_known(awaddr_ff) && awaddr_ff != OFS_STATE_FLAGS) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= CTL_RESET;
            sd_ff <= SD_RESET;
            tst_ff <= TST_RESET;
            seed_a_hi_ff <= 32'h0000_0000;
            seed_a_lo_ff <= 32'h0000_0000;
            seed_b_hi_ff <= 32'h0000_0000;
            seed_b_lo_ff <= 32'h0000_0000;
            txp_hi_ff <= 32'h0000_0000;
            txp_lo_ff <= 32'h0000_0000;
            rxp_hi_ff <= 32'h0000_0000;
            rxp_lo_ff <= 32'h0000_0000;
        end else if (wr_go) begin
            if (awaddr_ff == OFS_PCS_CONTROL) begin
                ctl_ff <= merge(ctl_ff, wdata_ff, wstrb_ff) & 32'h0000_000F;
            end else if (awaddr_ff == OFS_SIGDET_CONFIG) begin
                sd_ff <= merge(sd_ff, wdata_ff, wstrb_ff) & 32'h0000_0007;
            end else if (awaddr_ff == OFS_TEST_SETUP) begin
                tst_ff <= merge(tst_ff, wdata_ff, wstrb_ff) & 32'h0000_0033;
            end else if (awaddr_ff == OFS_SEED_A_UPPER) begin
                seed_a_hi_ff <= merge(seed_a_hi_ff, wdata_ff, wstrb_ff) & 32'h03FF_FFFF;
            end else if (awaddr_ff == OFS_SEED_A_LOWER) begin
                seed_a_lo_ff <= merge(seed_a_lo_ff, wdata_ff, wstrb_ff);
            end else if (awaddr_ff == OFS_SEED_B_UPPER) begin
                seed_b_hi_ff <= merge(seed_b_hi_ff, wdata_ff, wstrb_ff) & 32'h03FF_FFFF;
            end else if (awaddr_ff == OFS_SEED_B_LOWER) begin
                seed_b_lo_ff <= merge(seed_b_lo_ff, wdata_ff, wstrb_ff);
            end else if (awaddr_ff == OFS_TX_PAT_UPPER) begin
                txp_hi_ff <= merge(txp_hi_ff, wdata_ff, wstrb_ff);
            end else if (awaddr_ff == OFS_TX_PAT_LOWER) begin
                txp_lo_ff <= merge(txp_lo_ff, wdata_ff, wstrb_ff);
            end else if (awaddr_ff == OFS_RX_PAT_UPPER) begin
                rxp_hi_ff <= merge(rxp_hi_ff, wdata_ff, wstrb_ff);
            end else if (awaddr_ff == OFS_RX_PAT_LOWER) begin
                rxp_lo_ff <= merge(rxp_lo_ff, wdata_ff, wstrb_ff);
            end
        end
    end

    assign err_clr = wr_go && awaddr_ff == OFS_ERR_COUNT && wstrb_ff != 4'h0 && wdata_ff == 32'h0000_0000;

    // axi read side
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rd_mux;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    logic sd_active;
    logic rx_run;

    always_comb begin
        rd_mux = SLV_OKAY_RD;
        if (s_axi_araddr == OFS_PCS_CONTROL) begin
            rd_mux = ctl_ff;
        end else if (s_axi_araddr == OFS_SIGDET_CONFIG) begin
            rd_mux = sd_ff;
        end else if (s_axi_araddr == OFS_TEST_SETUP) begin
            rd_mux = tst_ff;
        end else if (s_axi_araddr == OFS_SEED_A_UPPER) begin
            rd_mux = seed_a_hi_ff;
        end else if (s_axi_araddr == OFS_SEED_A_LOWER) begin
            rd_mux = seed_a_lo_ff;
        end else if (s_axi_araddr == OFS_SEED_B_UPPER) begin
            rd_mux = seed_b_hi_ff;
        end else if (s_axi_araddr == OFS_SEED_B_LOWER) begin
            rd_mux = seed_b_lo_ff;
        end else if (s_axi_araddr == OFS_TX_PAT_UPPER) begin
            rd_mux = txp_hi_ff;
        end else if (s_axi_araddr == OFS_TX_PAT_LOWER) begin
            rd_mux = txp_lo_ff;
        end else if (s_axi_araddr == OFS_RX_PAT_UPPER) begin
            rd_mux = rxp_hi_ff;
        end else if (s_axi_araddr == OFS_RX_PAT_LOWER) begin
            rd_mux = rxp_lo_ff;
        end else if (s_axi_araddr == OFS_STATE_FLAGS) begin
            rd_mux[STA_MATCH_BIT] = match_ff;
            rd_mux[STA_SIGDET_BIT] = sd_active;
            rd_mux[STA_RX_RUN_BIT] = rx_run;
        end else if (s_axi_araddr == OFS_ERR_COUNT) begin
            rd_mux = 32'(err_cnt_ff);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // signal detect and receive state machine
    logic sd_raw;
    assign sd_raw = sd_ff[SD_SOURCE_BIT] ? gpio_sigdet : serdes_sigdet;
    assign sd_active = (sd_raw == sd_ff[SD_POLARITY_BIT]);

    typedef enum logic [1:0] {RX_RESTART, RX_RUNNING} bpcs_rx_e;
    bpcs_rx_e rx_state_ff;
    logic sig_lost;
    assign sig_lost = sd_ff[SD_ENABLE_BIT] && !sd_active;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_ff <= RX_RESTART;
        end else begin
            case (rx_state_ff)
                RX_RESTART: begin
                    if (!sig_lost) begin
                        rx_state_ff <= RX_RUNNING;
                    end
                end
                default: begin
                    if (sig_lost) begin
                        rx_state_ff <= RX_RESTART;
                    end
                end
            endcase
        end
    end
    assign rx_run = (rx_state_ff == RX_RUNNING);
    assign rx_restart = !rx_run;

    // pattern source: prbs31 state in bits 30:0 of each block, scrambler x58 for pseudo-random
    function automatic logic [30:0] prbs31_step(input logic [30:0] s);
        logic [30:0] r;
        r = s;
        for (int i = 0; i < 64; i++) begin
            r = {r[29:0], r[30] ^ r[27]};
        end
        return r;
    endfunction

    function automatic logic [121:0] scram(input logic [57:0] st, input logic [63:0] d);
        logic [57:0] s;
        logic [63:0] o;
        s = st;
        o = 64'h0;
        for (int i = 0; i < 64; i++) begin
            o[i] = d[i] ^ s[38] ^ s[57];
            s = {s[56:0], o[i]};
        end
        return {s, o};
    endfunction

    logic [63:0] tx_pat, rx_pat;
    logic [57:0] seed_sel;
    assign tx_pat = {txp_hi_ff, txp_lo_ff};
    assign rx_pat = {rxp_hi_ff, rxp_lo_ff};
    assign seed_sel = ctl_ff[CTL_SEED_B_BIT] ? {seed_b_hi_ff[SEED_UPPER_W-1:0], seed_b_lo_ff}
                                             : {seed_a_hi_ff[SEED_UPPER_W-1:0], seed_a_lo_ff};

    logic [1:0] tx_sel, rx_sel;
    assign tx_sel = tst_ff[TST_TX_SEL_LSB +: 2];
    assign rx_sel = tst_ff[TST_RX_SEL_LSB +: 2];

    logic [57:0] tx_scr_ff;
    logic [30:0] tx_prbs_ff;
    logic [7:0] tx_win_ff;
    bpcs_blk_s gen_blk;
    logic [121:0] tx_scr_nxt;
    assign tx_scr_nxt = scram(tx_scr_ff, tx_pat);

    always_comb begin
        gen_blk.hdr = 2'b01;
        if (tx_sel == PAT_SQUARE) begin
            gen_blk.data = SQUARE_HI;
        end else if (tx_sel == PAT_PRBS31) begin
            gen_blk.data = {33'h0, tx_prbs_ff};
        end else begin
            gen_blk.data = tx_scr_nxt[63:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_scr_ff <= 58'h0;
            tx_prbs_ff <= 31'h7FFF_FFFF;
            tx_win_ff <= 8'h00;
        end else if (!ctl_ff[CTL_TX_TEST_BIT]) begin
            tx_scr_ff <= seed_sel;
            tx_win_ff <= 8'h00;
        end else begin
            tx_prbs_ff <= prbs31_step(tx_prbs_ff);
            tx_win_ff <= (32'(tx_win_ff) == WINDOW_BLKS - 1) ? 8'h00 : tx_win_ff + 8'h01;
            if (32'(tx_win_ff) == WINDOW_BLKS - 1 && tx_sel == PAT_PSEUDO) begin
                tx_scr_ff <= seed_sel;
            end else begin
                tx_scr_ff <= tx_scr_nxt[121:64];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_out <= '0;
        end else begin
            tx_out <= ctl_ff[CTL_TX_TEST_BIT] ? gen_blk : tx_in;
        end
    end

    // receive source and checker
    bpcs_blk_s rx_src;
    assign rx_src = ctl_ff[CTL_LOOPBACK_BIT] ? tx_out : rx_in;

    logic [57:0] rx_scr_ff;
    logic [30:0] rx_prbs_ff;
    logic [63:0] exp_data;
    logic [121:0] rx_scr_nxt;
    logic chk_on, mis;
    assign chk_on = ctl_ff[CTL_RX_TEST_BIT] && rx_run;
    assign rx_scr_nxt = scram(rx_scr_ff, rx_pat);

    always_comb begin
        if (rx_sel == PAT_SQUARE) begin
            exp_data = SQUARE_HI;
        end else if (rx_sel == PAT_PRBS31) begin
            exp_data = {33'h0, rx_prbs_ff};
        end else begin
            exp_data = rx_pat ^ rx_scr_nxt[63:0] ^ rx_pat;
        end
    end
    assign mis = (rx_sel == PAT_PRBS31) ? (rx_src.data[30:0] != rx_prbs_ff) : (rx_src.data != exp_data);

    // self-synchronising: the checker follows the received bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_scr_ff <= 58'h0;
            rx_prbs_ff <= 31'h7FFF_FFFF;
        end else if (chk_on) begin
            rx_scr_ff <= {<<{rx_src.data[63:6]}};
            rx_prbs_ff <= prbs31_step(rx_src.data[30:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= chk_on && !mis;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_cnt_ff <= '0;
        end else if (chk_on && mis && !(&err_cnt_ff)) begin
            err_cnt_ff <= err_cnt_ff + 1'b1;
        end else if (err_clr && !(chk_on && mis)) begin
            err_cnt_ff <= '0;
        end
    end

    // two-entry skid buffer toward the receive consumer
    bpcs_blk_s buf_ff [2];
    logic [1:0] buf_cnt_ff;
    logic push, pop;
    assign push = rx_run && !ctl_ff[CTL_RX_TEST_BIT] && buf_cnt_ff != 2'd2;
    assign pop = rx_out_valid && rx_out_ready;
    assign rx_out_valid = (buf_cnt_ff != 2'd0);
    assign rx_out = buf_ff[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_cnt_ff <= 2'd0;
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
        end else if (!rx_run) begin
            buf_cnt_ff <= 2'd0;
        end else begin
            if (pop) begin
                buf_ff[0] <= buf_ff[1];
            end
            if (push) begin
                if (buf_cnt_ff == 2'd0 || (buf_cnt_ff == 2'd1 && pop)) begin
                    buf_ff[0] <= rx_src;
                end else begin
                    buf_ff[1] <= rx_src;
                end
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ### sim/bpcs_serdes_model.sv
/*
 * line-side serdes model for bpcs_top: sends a counting block every cycle
 * and reports its own signal detect. assumes the bench sets the line level.
 */
`timescale 1ns/1ps
module bpcs_serdes_model
    import bpcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic line_level,
    output bpcs_blk_s rx_blk,
    output logic sigdet
);
    logic [63:0] cnt_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 64'h0000_0000_0000_0000;
        end else begin
            cnt_ff <= cnt_ff + 64'h0000_0000_0000_0001;
        end
    end
    assign rx_blk = '{hdr: 2'h1, data: cnt_ff};
    // detect comes from the serdes pin
    assign sigdet = line_level;
endmodule

// ### sim/bpcs_top_monitor.sv
/*
 * checker for bpcs_top: bus answer timing, tx pass-through, signal detect
 * restart and receive buffer hold. assumes address and data are offered together.
 */
`timescale 1ns/1ps
module bpcs_monitor
    import bpcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire bpcs_blk_s tx_in,
    input wire bpcs_blk_s tx_out,
    input wire logic serdes_sigdet,
    input wire logic gpio_sigdet,
    input wire bpcs_blk_s rx_out,
    input wire logic rx_out_valid,
    input wire logic rx_out_ready,
    input wire logic rx_restart
);
    logic [31:0] ctl_ff, sd_ff, wd_ff;
    logic [7:0] wa_ff;
    logic wp_ff;
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire sd_lvl = sd_ff[SD_SOURCE_BIT] ? gpio_sigdet : serdes_sigdet;
    wire loss = sd_ff[SD_ENABLE_BIT] && (sd_lvl != sd_ff[SD_POLARITY_BIT]);
    // setting mirrors, updated one cycle after the handshake like the slave
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= 1'b0;
            wa_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            ctl_ff <= CTL_RESET;
            sd_ff <= SD_RESET;
        end else begin
            wp_ff <= wr_hs;
            wa_ff <= s_axi_awaddr;
            wd_ff <= s_axi_wdata;
            if (wp_ff && wa_ff == OFS_PCS_CONTROL) ctl_ff <= wd_ff;
            if (wp_ff && wa_ff == OFS_SIGDET_CONFIG) sd_ff <= wd_ff;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence wr_taken;
        wr_hs;
    endsequence
    sequence b_late;
        ##2 s_axi_bvalid;
    endsequence
    wr_answer_a: assert property (
        wr_taken |-> b_late) else $error("write answer not on time");
    ro_write_a: assert property (
        (wr_hs && s_axi_awaddr == OFS_STATE_FLAGS) |-> b_late ##0 (s_axi_bresp == RESP_SLVERR))
        else $error("status write not refused");
    bus_busy_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while answering");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    tx_pass_a: assert property (
        !ctl_ff[CTL_TX_TEST_BIT] |=> tx_out == $past(tx_in)) else $error("tx pass-through broken");
    sd_restart_a: assert property (
        loss |=> rx_restart) else $error("signal loss without restart");
    sd_ignore_a: assert property (
        !sd_ff[SD_ENABLE_BIT] [*4] |-> !rx_restart) else $error("restart while detect disabled");
    restart_flush_a: assert property (
        rx_restart |=> !rx_out_valid) else $error("receive output during restart");
    buf_hold_a: assert property (
        rx_out_valid && !rx_out_ready && !loss |=> rx_out_valid && $stable(rx_out))
        else $error("stalled block lost");
endmodule
bind bpcs_top bpcs_monitor i_bpcs_monitor (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .tx_in, .tx_out, .serdes_sigdet, .gpio_sigdet, .rx_out,
    .rx_out_valid, .rx_out_ready, .rx_restart
);

// ### sim/baser_pcs_sd_loopback_testpat_tb.sv
/*
 * testbench for bpcs_top: registers, signal detect, loopback, buffer stall,
 * pattern modes and error counter. assumes the serdes model on the line side.
 */
`timescale 1ns/1ps
module baser_pcs_sd_loopback_testpat_tb
    import bpcs_pkg::*;
;
    localparam int ERR_W = 4;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic sys_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, gpio_sigdet = 1'b0, sd_lvl = 1'b1, rx_out_ready = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, o;
    logic [31:0] s_axi_wdata = 32'h0000_0000, r = 32'h0000_0013, v, mw, s_axi_rdata, qm[$];
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic serdes_sigdet, rx_out_valid, rx_restart;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] ew, qe[$];
    bpcs_blk_s tx_in = '0, tx_out, rx_in, rx_out, h;
    int err_count = 0, checks = 0;

    bpcs_serdes_model i_bpcs_serdes_model (.sys_clk, .rst_n, .line_level(sd_lvl), .rx_blk(rx_in),
        .sigdet(serdes_sigdet));
    bpcs_top #(.ERR_W(ERR_W), .WINDOW_BLKS(16)) i_bpcs_top (.sys_clk, .rst_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_in, .tx_out, .rx_in,
        .serdes_sigdet, .gpio_sigdet, .rx_out, .rx_out_valid, .rx_out_ready, .rx_restart);

    always #2 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [33:0] ok(input logic [31:0] d);
        return {RESP_OKAY, d};
    endfunction
    task automatic check(input string n, input logic [67:0] s, input logic [67:0] x);
        checks++;
        if (s !== x) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, x, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        qe.push_back({e, 32'h0000_0000});
        qm.push_back(32'h0000_0000);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
        qe.push_back(e);
        qm.push_back(m);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask

    always @(posedge sys_clk) begin
        r <= lfsr(r);
        tx_in <= '{hdr: 2'h2, data: {r, ~r}};
    end
    // compares each bus answer with the oldest note
    always @(posedge sys_clk) begin
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
            ew = qe.pop_front();
            mw = qm.pop_front();
            if (s_axi_rvalid) check("rd", {s_axi_rresp, s_axi_rdata & mw}, ew);
            else check("wr", {s_axi_bresp, 32'h0000_0000}, ew);
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_PCS_CONTROL, ok(CTL_RESET), ALL);
        rd(OFS_SIGDET_CONFIG, ok(SD_RESET), ALL);
        rd(OFS_TEST_SETUP, ok(TST_RESET), ALL);
        rd(8'h3C, {RESP_SLVERR, 32'h0000_0000}, ALL);
        wr(OFS_STATE_FLAGS, ALL, RESP_SLVERR);
        for (o = OFS_SEED_A_UPPER; o <= OFS_RX_PAT_LOWER; o += 8'h04) begin
            v = r;
            wr(o, v, RESP_OKAY);
            if (o == OFS_SEED_A_UPPER || o == OFS_SEED_B_UPPER) v = v & ((32'h1 << SEED_UPPER_W) - 32'h1);
            rd(o, ok(v), ALL);
        end
        for (o = OFS_TX_PAT_UPPER; o <= OFS_RX_PAT_LOWER; o += 8'h04) wr(o, o[2] ? 32'hC3A5_0F96 : ~r, RESP_OKAY);
        wr(OFS_RX_PAT_LOWER, 32'h5A3C_E187, RESP_OKAY);
        wr(OFS_TX_PAT_LOWER, 32'h5A3C_E187, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SIGDET_CONFIG, {29'h0, i[1:0], 1'b1}, RESP_OKAY);
            {gpio_sigdet, sd_lvl} <= i[1] ? {i[0], ~i[0]} : {~i[0], i[0]};
            repeat (5) @(posedge sys_clk);
            check("run", rx_restart, 1'b0);
            {gpio_sigdet, sd_lvl} <= ~{gpio_sigdet, sd_lvl};
            repeat (3) @(posedge sys_clk);
            check("restart", {rx_restart, rx_out_valid}, 2'h2);
            wr(OFS_SIGDET_CONFIG, {29'h0, i[1:0], 1'b0}, RESP_OKAY);
            repeat (5) @(posedge sys_clk);
            check("ignored", {rx_restart, rx_out_valid}, 2'h1);
        end
        for (int l = 0; l < 2; l++) begin
            wr(OFS_PCS_CONTROL, {29'h0, l[0], 2'h0}, RESP_OKAY);
            repeat (6) @(posedge sys_clk);
            check("path", rx_out.hdr, l ? 2'h2 : 2'h1);
        end
        rx_out_ready <= 1'b0;
        repeat (6) @(posedge sys_clk);
        h = rx_out;
        rx_out_ready <= 1'b1;
        @(posedge sys_clk);
        check("held", {rx_out_valid, rx_out}, {1'b1, h});
        for (int m = 0; m < 4; m++) begin
            wr(OFS_TEST_SETUP, {26'h0, m[1:0], 2'h0, m[1:0]}, RESP_OKAY);
            wr(OFS_PCS_CONTROL, {28'h0, m == 1, 3'h7}, RESP_OKAY);
            repeat (100) @(posedge sys_clk);
            wr(OFS_ERR_COUNT, 32'h0000_0000, RESP_OKAY);
            repeat (60) @(posedge sys_clk);
            check("drained", rx_out_valid, 1'b0);
            if (m != 1) begin
                rd(OFS_ERR_COUNT, ok(32'h0000_0000), ALL);
                rd(OFS_STATE_FLAGS, ok(32'h0000_0001), 32'h0000_0001);
            end
        end
        wr(OFS_PCS_CONTROL, 32'h0000_0006, RESP_OKAY);
        repeat (60) @(posedge sys_clk);
        rd(OFS_STATE_FLAGS, ok(32'h0000_0000), 32'h0000_0001);
        wr(OFS_PCS_CONTROL, 32'h0000_0004, RESP_OKAY);
        rd(OFS_ERR_COUNT, ok((32'h1 << ERR_W) - 32'h1), ALL);
        wr(OFS_ERR_COUNT, 32'h0000_0000, RESP_OKAY);
        rd(OFS_ERR_COUNT, ok(32'h0000_0000), ALL);
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        stop_test;
    end
endmodule
